// ---- src/strap_bus_decode.sv ----
// strap-configured host bus decode of the disk interface card
// Notes on behaviour
// - seven vector straps give vector bits 2..8
// - vector bits 1..0 always zero
// - shipped vector straps give vector 264
// - shunts 3..12 give register address bits
// - shipped shunts decode base 777170
// - two straps place boot rom window
// - rom window spans 256 words
// - boot disable strap mutes rom window
// - jumpers pick request level 4 to 7
// - mode jumper installed means legacy mode
// - device takes and relays non-processor grant
// - twelve-bit variant answers the jumpered device code, 75 with shipped jumpers
// - boot strap shorted disables, open enables
`default_nettype none
`include "strap_bus_cfg.svh"
module strap_bus_decode (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // board straps, pin level: closed reads 0, open reads 1
    input wire logic [6:0] VECTOR_BIT_STRAPS,
    input wire logic [9:0] ADDR_SHUNTS,
    input wire logic [1:0] ROM_PLACE_STRAPS,
    input wire logic BOOT_DISABLE_STRAP,
    input wire logic [1:0] LEVEL_JUMPERS,
    input wire logic LEGACY_MODE_JUMPER,
    input wire logic [5:0] DEV_CODE_JUMPERS,
    // address cycle on the host bus clock
    input wire logic [17:0] BUS_ADDR,
    input wire logic ADDR_STROBE,
    input wire logic [5:0] IOT_CODE,
    input wire logic IOT_STROBE,
    // requests from the device core
    input wire logic IRQ_REQ,
    input wire logic DMA_REQ,
    // grant chains
    input wire logic IRQ_GRANT_IN,
    input wire logic DMA_GRANT_CHAIN_IN,
    output logic IRQ_GRANT_OUT,
    output logic DMA_GRANT_CHAIN_OUT,
    output logic IRQ_TAKEN,
    output logic DMA_TAKEN,
    // selects
    output logic REG_SEL,
    output logic [1:0] REG_WORD,
    output logic ROM_SEL,
    output logic [7:0] ROM_WORD,
    output logic DEV_SEL,
    // configuration views
    output logic [8:0] VECTOR,
    output logic REQUEST_LEVEL_FOUR,
    output logic REQUEST_LEVEL_FIVE,
    output logic REQUEST_LEVEL_SIX,
    output logic REQUEST_LEVEL_SEVEN,
    output logic EXTENDED_MODE
);
    localparam int STRAP_W = 29; // every strap pin, packed together

    // raw pins and their shipped levels, packed in one order
    logic [STRAP_W-1:0] strap_pins;
    // three-stage synchroniser and the accepted strap image
    logic [STRAP_W-1:0] sync1_ff, sync2_ff, sync3_ff;
    logic [STRAP_W-1:0] strap_ff;

    assign strap_pins = {VECTOR_BIT_STRAPS, ADDR_SHUNTS, ROM_PLACE_STRAPS,
                         BOOT_DISABLE_STRAP, LEVEL_JUMPERS, LEGACY_MODE_JUMPER,
                         DEV_CODE_JUMPERS};
    // shipped board image, a constant so the reset branches load constants only
    localparam logic [STRAP_W-1:0] STRAP_RST = {`VEC_STRAP_RST, `ADDR_SHUNT_RST,
        `ROM_PLACE_RST, `BOOT_STRAP_RST, `LEVEL_STRAP_RST,
        `MODE_JUMPER_RST, `DEV_JUMPER_RST};

    // unpacked strap fields
    wire logic [6:0] vec_straps = strap_ff[28:22];
    wire logic [9:0] addr_shunts = strap_ff[21:12];
    wire logic [1:0] rom_place = strap_ff[11:10];
    wire logic boot_open = strap_ff[9];
    wire logic [1:0] level_sel = strap_ff[8:7];
    wire logic mode_open = strap_ff[6];
    wire logic [5:0] dev_jumpers = strap_ff[5:0];

    // synchroniser chain; straps are static but pins bounce when moved
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            // shipped levels here, or the image would fall to all-closed after reset
            sync1_ff <= STRAP_RST;
            sync2_ff <= STRAP_RST;
            sync3_ff <= STRAP_RST;
        end else begin
            sync1_ff <= strap_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // a strap bit changes only once stages two and three agree
    wire logic [STRAP_W-1:0] nxt_strap; // accepted image for the next edge
    genvar b;
    generate
        for (b = 0; b < STRAP_W; b++) begin : g_strap
            // disagreeing stages keep the old level, so a one-sample bounce never lands
            assign nxt_strap[b] = (sync2_ff[b] == sync3_ff[b]) ? sync3_ff[b] : strap_ff[b];
        end
    endgenerate

    // accepted strap image, one process so the register has one driver
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            strap_ff <= STRAP_RST;
        end else begin
            strap_ff <= nxt_strap;
        end
    end

    // window compare used by register and rom decode alike
    function automatic logic win_hit(input logic [17:0] a, input logic [17:0] base,
                                     input int lsb);
        logic [17:0] mask;
        mask = 18'h3ffff << lsb;
        win_hit = ((a ^ base) & mask) == 18'h00000;
    endfunction

    // register base: top page prefix plus shunted bits 12..3
    wire logic [17:0] reg_base = {`IO_PAGE_HI, addr_shunts, 3'h0};
    wire logic reg_hit = win_hit(BUS_ADDR, reg_base, `REG_MATCH_LSB);

    // rom base from the two placement straps, {pos1, pos2}
    logic [17:0] rom_base;
    always_comb begin
        case (rom_place)
            2'h3: rom_base = `ROM_BASE_OPEN_OPEN;
            2'h2: rom_base = `ROM_BASE_OPEN_CLSD;
            2'h1: rom_base = `ROM_BASE_CLSD_OPEN;
            2'h0: rom_base = `ROM_BASE_CLSD_CLSD;
            default: rom_base = `ROM_BASE_OPEN_CLSD;
        endcase
    end
    // 256-word window; shorted boot strap drops every rom address
    wire logic rom_hit = boot_open
        & win_hit(BUS_ADDR, rom_base, `ROM_MATCH_LSB);

    // device code: an installed jumper pulls low and counts as a one
    wire logic [5:0] dev_code = ~dev_jumpers;
    wire logic dev_hit = (IOT_CODE == dev_code);

    // registered selects, one cycle after the strobe
    logic reg_sel_ff, rom_sel_ff, dev_sel_ff;
    logic [1:0] reg_word_ff;
    logic [7:0] rom_word_ff;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            reg_sel_ff <= 1'b0;
            rom_sel_ff <= 1'b0;
            dev_sel_ff <= 1'b0;
            reg_word_ff <= 2'h0;
            rom_word_ff <= 8'h00;
        end else begin
            reg_sel_ff <= ADDR_STROBE & reg_hit;
            rom_sel_ff <= ADDR_STROBE & rom_hit;
            dev_sel_ff <= IOT_STROBE & dev_hit;
            reg_word_ff <= BUS_ADDR[`REG_WORD_W:1];
            rom_word_ff <= BUS_ADDR[`ROM_WORD_W:`ROM_WORD_LSB];
        end
    end

    // vector and level images, held in flops for clean outputs
    logic [8:0] vector_ff;
    logic [3:0] level_ff;
    logic mode_ff;
    wire logic [3:0] level_onehot = 4'h1 << level_sel;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            vector_ff <= 9'h000;
            level_ff <= 4'h0;
            mode_ff <= 1'b1;
        end else begin
            vector_ff <= {vec_straps, 2'h0};
            level_ff <= IRQ_REQ ? level_onehot : 4'h0;
            mode_ff <= mode_open;
        end
    end

    // grant chains, relayed by the submodule
    grant_if gif();
    assign gif.req = {DMA_REQ, IRQ_REQ};
    assign gif.gnt_in = {DMA_GRANT_CHAIN_IN, IRQ_GRANT_IN};
    grant_relay u_relay (
        .clk(CLOCK),
        .rst_n(RST_N),
        .g(gif.relay)
    );

    assign IRQ_GRANT_OUT = gif.gnt_out[0];
    assign DMA_GRANT_CHAIN_OUT = gif.gnt_out[1];
    assign IRQ_TAKEN = gif.taken[0];
    assign DMA_TAKEN = gif.taken[1];
    assign REG_SEL = reg_sel_ff;
    assign REG_WORD = reg_word_ff;
    assign ROM_SEL = rom_sel_ff;
    assign ROM_WORD = rom_word_ff;
    assign DEV_SEL = dev_sel_ff;
    assign VECTOR = vector_ff;
    assign {REQUEST_LEVEL_SEVEN, REQUEST_LEVEL_SIX, REQUEST_LEVEL_FIVE,
            REQUEST_LEVEL_FOUR} = level_ff;
    assign EXTENDED_MODE = (mode_ff == strap_bus_pkg::MODE_EXTENDED);

    // checks on the decode
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    property p_vec_low;
        VECTOR[1:0] == 2'h0;
    endproperty
    a_vec_low: assert property (p_vec_low) else $error("vector low bits set");

    property p_vec_follow;
        $stable(vec_straps) [*2] |-> VECTOR[8:2] == vec_straps;
    endproperty
    a_vec_follow: assert property (p_vec_follow) else $error("vector lags straps");

    property p_reg_match;
        REG_SEL |-> $past(ADDR_STROBE) && ($past(BUS_ADDR[17:3]) == $past(reg_base[17:3]));
    endproperty
    a_reg_match: assert property (p_reg_match) else $error("bad register select");

    property p_reg_hit;
        ADDR_STROBE && BUS_ADDR[17:3] == {`IO_PAGE_HI, addr_shunts} |=> REG_SEL;
    endproperty
    a_reg_hit: assert property (p_reg_hit) else $error("register select missed");

    property p_rom_off;
        !boot_open ##1 !boot_open |-> !ROM_SEL;
    endproperty
    a_rom_off: assert property (p_rom_off) else $error("rom answered while disabled");

    property p_rom_win;
        ROM_SEL |-> $past(BUS_ADDR[17:9]) == $past(rom_base[17:9]);
    endproperty
    a_rom_win: assert property (p_rom_win) else $error("rom outside window");

    property p_level;
        IRQ_REQ ##1 $stable(level_sel) |-> $onehot(level_ff) && level_ff[level_sel];
    endproperty
    a_level: assert property (p_level) else $error("wrong request level");

    property p_mode;
        $stable(mode_open) [*2] |-> EXTENDED_MODE == mode_open;
    endproperty
    a_mode: assert property (p_mode) else $error("mode mismatch");

    property p_grant;
        !(IRQ_REQ && IRQ_GRANT_OUT) && !(DMA_REQ && DMA_GRANT_CHAIN_OUT);
    endproperty
    a_grant: assert property (p_grant) else $error("grant passed while requesting");

    property p_dev;
        DEV_SEL |-> $past(IOT_STROBE) && $past(IOT_CODE) == $past(~dev_jumpers);
    endproperty
    a_dev: assert property (p_dev) else $error("bad device code select");

    property p_cov_reg;
        ADDR_STROBE ##1 REG_SEL;
    endproperty
    c_cov_reg: cover property (p_cov_reg);
    property p_cov_rom;
        ADDR_STROBE ##1 ROM_SEL;
    endproperty
    c_cov_rom: cover property (p_cov_rom);
    property p_cov_dma;
        DMA_REQ && DMA_GRANT_CHAIN_IN ##1 DMA_TAKEN;
    endproperty
    c_cov_dma: cover property (p_cov_dma);
endmodule
`default_nettype wire

// ---- inc/strap_bus_cfg.svh ----
// constants for the strap-configured bus decode: addresses, strap defaults, widths
`ifndef STRAP_BUS_CFG_SVH
`define STRAP_BUS_CFG_SVH

// bus address width and the top i/o page prefix (bits 17..13 all ones)
`define BUS_ADDR_W 18
`define IO_PAGE_HI 5'h1f
// boot rom starting addresses, 777170 = 18'h3fe78 for reference
`define ROM_BASE_OPEN_OPEN 18'h3f600
`define ROM_BASE_OPEN_CLSD 18'h3f200
`define ROM_BASE_CLSD_OPEN 18'h3fa00
`define ROM_BASE_CLSD_CLSD 18'h3ec00
// boot rom window: 256 words, address bits 8..1 pick the word
`define ROM_WORD_LSB 1
`define ROM_WORD_W 8
`define ROM_MATCH_LSB 9
// device register block: base at bit 3, words picked by bits 2..1
`define REG_MATCH_LSB 3
`define REG_WORD_W 2
// twelve-bit host device code, 75 octal
`define DEV_CODE 6'h3d
// strap levels after reset, matching the shipped board
`define VEC_STRAP_RST 7'h2d
`define ADDR_SHUNT_RST 10'h3cf
`define ROM_PLACE_RST 2'h2
`define BOOT_STRAP_RST 1'h1
`define LEVEL_STRAP_RST 2'h1
`define MODE_JUMPER_RST 1'h1
`define DEV_JUMPER_RST 6'h02

`endif

// ---- inc/strap_bus_pkg.sv ----
// types shared by the strap-configured bus decode
`default_nettype none
package strap_bus_pkg;
    // operating mode chosen by the mode jumper
    typedef enum logic {MODE_LEGACY, MODE_EXTENDED} op_mode_t;
    // bus address carried on the backplane
    typedef logic [17:0] bus_addr_t;
    // index of a grant chain handled by the relay
    typedef enum int {CHAIN_IRQ, CHAIN_DMA} chain_t;
endpackage
`default_nettype wire

// ---- inc/grant_if.sv ----
// grant daisy-chain signals passed between the decode top and its relay
`default_nettype none
interface grant_if;
    logic [1:0] req;     // device wants the chain, per chain
    logic [1:0] gnt_in;  // grant arriving from the processor side
    logic [1:0] gnt_out; // grant passed on downstream
    logic [1:0] taken;   // grant held by this device
    modport relay(input req, input gnt_in, output gnt_out, output taken);
    modport user(output req, output gnt_in, input gnt_out, input taken);
endinterface
`default_nettype wire

// ---- src/grant_relay.sv ----
// grant relay: takes a chain grant when requesting, passes it on otherwise
`default_nettype none
module grant_relay (
    input wire logic clk,
    input wire logic rst_n,
    grant_if.relay g
);
    logic [1:0] taken_ff; // grant registered each edge while both it and our request stand
    wire logic [1:0] nxt_taken; // grant captured instead of forwarded, per chain

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chain
            // combinational pass-on keeps chain latency to a gate
            assign g.gnt_out[i] = g.gnt_in[i] & ~g.req[i];
            // capture the grant instead of forwarding it
            assign nxt_taken[i] = g.gnt_in[i] & g.req[i];
        end
    endgenerate

    // one process for both chains keeps a single driver on the register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_ff <= 2'h0;
        end else begin
            taken_ff <= nxt_taken;
        end
    end

    assign g.taken = taken_ff;
endmodule
`default_nettype wire

// ---- testbench/host_grant_model.sv ----
// host side of the grant chains: processor issues grants down the daisy chain
`default_nettype none
module host_grant_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // arbitration request from the bench, grants taken by the card
    input wire logic go,
    input wire logic irq_taken,
    input wire logic dma_taken,
    // grants driven into the card slot
    output logic irq_gnt,
    output logic dma_gnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // no empty slot between processor and card, so grants reach it directly
    // no grant-in to grant-out bypass at the slot: the card relays it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_gnt <= 1'b0;
            dma_gnt <= 1'b0;
        end else if (go) begin
            irq_gnt <= 1'b1;
            dma_gnt <= 1'b1;
        end else begin
            // a taken grant is withdrawn, as a processor would after the transfer
            irq_gnt <= irq_gnt & ~irq_taken;
            dma_gnt <= dma_gnt & ~dma_taken;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/strap_bus_decode_tb_top.sv ----
// self-checking bench for the strap-configured bus decode
`default_nettype none
module strap_bus_decode_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0;
    // straps start at the shipped board image
    logic [6:0] vec = 7'h2d;
    logic [9:0] shunt = 10'h3cf;
    logic [1:0] place = 2'h2, lvl = 2'h1;
    logic boot = 1'b1, legacy = 1'b1;
    logic [5:0] devj = 6'h02, iot = 6'h00;
    // bus stimulus
    logic [17:0] addr = 18'h0;
    logic astb = 1'b0, istb = 1'b0, irq = 1'b0, dma = 1'b0, go = 1'b0;
    // observed outputs
    logic igi, dgi, igo, dgo, itk, dtk, rsel, msel, dsel, ext, l4, l5, l6, l7;
    logic [1:0] rword;
    logic [7:0] mword;
    logic [8:0] vector;
    int err_count = 0, n_tests = 0;
    logic [15:0] r = 16'h1;
    strap_bus_decode i_dut (.CLOCK(clk), .RST_N(rst_n), .VECTOR_BIT_STRAPS(vec),
        .ADDR_SHUNTS(shunt), .ROM_PLACE_STRAPS(place), .BOOT_DISABLE_STRAP(boot),
        .LEVEL_JUMPERS(lvl), .LEGACY_MODE_JUMPER(legacy), .DEV_CODE_JUMPERS(devj),
        .BUS_ADDR(addr), .ADDR_STROBE(astb), .IOT_CODE(iot), .IOT_STROBE(istb),
        .IRQ_REQ(irq), .DMA_REQ(dma), .IRQ_GRANT_IN(igi), .DMA_GRANT_CHAIN_IN(dgi),
        .IRQ_GRANT_OUT(igo), .DMA_GRANT_CHAIN_OUT(dgo), .IRQ_TAKEN(itk), .DMA_TAKEN(dtk),
        .REG_SEL(rsel), .REG_WORD(rword), .ROM_SEL(msel), .ROM_WORD(mword), .DEV_SEL(dsel),
        .VECTOR(vector), .REQUEST_LEVEL_FOUR(l4), .REQUEST_LEVEL_FIVE(l5),
        .REQUEST_LEVEL_SIX(l6), .REQUEST_LEVEL_SEVEN(l7), .EXTENDED_MODE(ext));
    host_grant_model i_host (.clk(clk), .rst_n(rst_n), .go(go), .irq_taken(itk),
        .dma_taken(dtk), .irq_gnt(igi), .dma_gnt(dgi));
    // 50 ns bus clock
    initial begin
        forever #25 clk = ~clk;
    end
    // pseudo-random source for strap images
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // expected rom start from the two placement straps {position 1, position 2}
    function automatic logic [17:0] rbase(logic [1:0] p);
        case (p)
            2'h3: return 18'h3f600; // 773000 octal
            2'h2: return 18'h3f200; // 771000 octal
            2'h1: return 18'h3fa00; // 775000 octal
            default: return 18'h3ec00; // 766000 octal
        endcase
    endfunction
    // single comparison point, counts every check
    task automatic chk(string name, logic [17:0] seen, logic [17:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // inputs always change 1 ns after the rising edge
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // one address cycle; selects are looked at in the single cycle they stand
    task automatic ac(logic [17:0] a);
        logic er, em;
        er = (a[17:3] == {5'h1f, shunt});
        em = boot && (a[17:9] == rbase(place) >> 9);
        addr = a;
        astb = 1'b1;
        step();
        astb = 1'b0;
        chk("reg_sel", rsel, er);
        chk("rom_sel", msel, em);
        if (er) chk("reg_word", rword, a[2:1]);
        if (em) chk("rom_word", mword, a[8:1]);
        // an idle edge, so the strobe is never lowered and raised in one time step
        step();
        chk("reg_sel_end", rsel, 1'b0);
        chk("rom_sel_end", msel, 1'b0);
    endtask
    // device code cycle on the twelve-bit host side
    task automatic dc(logic [5:0] c);
        iot = c;
        istb = 1'b1;
        step();
        istb = 1'b0;
        chk("dev_sel", dsel, c == ~devj);
        step();
        chk("dev_sel_end", dsel, 1'b0);
    endtask
    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    initial begin
        repeat (6) step();
        rst_n = 1'b1;
        repeat (6) step();
        // shipped image
        chk("vector", vector, 9'h0b4);
        ac(18'h3fe7a);
        ac(18'h3f204);
        dc(6'h3d);
        // grant relay: held while requesting, then taken
        irq = 1'b1;
        dma = 1'b1;
        go = 1'b1;
        step();
        go = 1'b0;
        chk("grant_out", {igo, dgo}, 2'b00);
        step();
        chk("taken", {itk, dtk}, 2'b11);
        irq = 1'b0;
        dma = 1'b0;
        go = 1'b1;
        step();
        go = 1'b0;
        chk("grant_out", {igo, dgo}, 2'b11);
        // random strap images, every rom placement and level visited
        for (int i = 0; i < 8; i++) begin
            r = lfsr(r);
            vec = r[6:0];
            legacy = r[7];
            boot = r[8];
            devj = r[14:9];
            r = lfsr(r);
            shunt = r[9:0];
            place = i[1:0];
            lvl = i[2:1];
            repeat (6) step();
            chk("vector", vector, {vec, 2'b00});
            chk("vec_low", vector[1:0], 2'b00);
            chk("ext_mode", ext, legacy);
            ac({5'h1f, shunt, i[1:0], 1'b1});
            ac({5'h1f, shunt, 3'h0} ^ 18'h8);
            ac({5'h1e, shunt, 3'h6});
            ac(rbase(place));
            ac(rbase(place) + 18'h001fe);
            ac(rbase(place) + 18'h00200);
            ac({r[15:0], 2'b00});
            dc(~devj);
            dc(devj);
            irq = 1'b1;
            step();
            chk("level", {l7, l6, l5, l4}, 4'h1 << lvl);
            irq = 1'b0;
            step();
            chk("level_idle", {l7, l6, l5, l4}, 4'h0);
        end
        test_done();
    end
endmodule
`default_nettype wire
